// *** src/balance_watchdog.sv ***
// Acquisition configuration register, balancing watchdog and aux settling sequencer
//
// Summary of operation
// - Reserved bits 15:14 and 7:6 ignore writes and read back as zero.
// - Predivider code zero disables the timeout; enabled switches stay on unless overtemperature forces them off.
// - Predivider codes give timer steps of one, four or sixteen seconds.
// - The four-bit timer counts down by one at each selected step.
// - A timer at zero forces every balancing switch off unless the predivider code is zero.
// - Read-all reports the timer value captured at the ninth bit time.
// - Aux field sets settling time in 5.3 us steps up to 339.2 us.
// - Aux field resets to zero, giving the minimum 5.3 us settling.
// - Full settling time precedes conversion of each enabled aux channel.
// - Thermistor bias is driven only while the measurement sequence runs.
// - Enable bits drive switches; watchdog and overtemperature override separately.
`timescale 1ns/1ps
`default_nettype none
`include "balance_watchdog_defs.svh"
module balance_watchdog
  import balance_watchdog_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `BAL_SEC_CYCLES
) (
  input  wire logic                    clk_in,
  input  wire logic                    reset_in,
  input  wire logic                    reg_wr_in,
  input  wire logic [7:0]              reg_addr_in,
  input  wire logic [15:0]             reg_wdata_in,
  input  wire logic                    read_capture_in,
  output logic      [15:0]             reg_rdata_out,
  input  wire logic [`CELL_COUNT-1:0]  cell_balance_enable_in,
  input  wire logic                    die_overtemp_in,
  output logic      [`CELL_COUNT-1:0]  balance_switch_out,
  input  wire logic                    scan_start_in,
  input  wire logic [1:0]              aux_enable_in,
  input  wire logic                    conv_done_in,
  output logic                         aux_convert_start_out,
  output logic                         aux_channel_out,
  output logic                         thermistor_bias_out,
  output logic                         scan_busy_out
);
  // Register fields
  pdiv_t      balance_predivider_reg;
  timer_t     balance_timeout_count_reg;
  timer_t     timer_shown_reg;
  aux_t       aux_settle_count_reg;
  logic [4:0] step_count_reg;
  logic [15:0] rdata_reg;
  // Overtemperature synchroniser
  logic       ot_s1_reg;
  logic       ot_s2_reg;
  logic       ot_s3_reg;
  logic       ot_level_reg;
  // Switch outputs
  logic [`CELL_COUNT-1:0] switch_reg;
  // Sequencer
  seq_state_e state_reg;
  seq_state_e state_next;
  aux_t       settle_left_reg;
  aux_t       settle_field_reg;
  logic       chan_reg;
  logic       convert_pulse_reg;
  logic       bias_reg;

  tick_if sec_if ();
  tick_if aux_if ();

  // One second base tick, restarted by a timer write
  // Cycle counted seconds
  interval_tick #(.PERIOD(SEC_CYCLES)) u_sec_tick (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .port_if  (sec_if)
  );

  // 5.3 us settling increment
  // Cycle counted settle step
  interval_tick #(.PERIOD(`AUX_STEP_CYCLES)) u_aux_tick (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .port_if  (aux_if)
  );

  // Register decode
  wire        addr_hit;
  wire        cfg_write;
  assign addr_hit  = (reg_addr_in == `ACQ_CONFIG_ADDR);
  assign cfg_write = reg_wr_in && addr_hit;

  // Predivider step selection
  wire [4:0]  step_last;
  wire        timeout_on;
  wire        timer_zero;
  wire        step_pulse;
  assign step_last  = (balance_predivider_reg == `PDIV_1S) ? `STEP_1S_M1 :
                      (balance_predivider_reg == `PDIV_4S) ? `STEP_4S_M1 : `STEP_16S_M1;
  assign timeout_on = (balance_predivider_reg != `PDIV_OFF);
  assign timer_zero = (balance_timeout_count_reg == `TMR_ZERO);
  assign step_pulse = sec_if.tick && (step_count_reg == step_last) && timeout_on && !cfg_write;
  assign sec_if.restart = cfg_write;

  // Configuration fields; reserved bits are never stored
  // Reserved writes dropped
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      balance_predivider_reg <= `PDIV_OFF;
      aux_settle_count_reg   <= `AUX_ZERO;
    end
    else if (cfg_write)
    begin
      balance_predivider_reg <= reg_wdata_in[`PDIV_MSB:`PDIV_LSB];
      aux_settle_count_reg   <= reg_wdata_in[`AUX_MSB:`AUX_LSB];
    end
  end

  // Watchdog count; a host load beats a step in the same cycle
  // Immediate timer load
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      balance_timeout_count_reg <= `TMR_ZERO;
    else if (cfg_write)
      balance_timeout_count_reg <= reg_wdata_in[`TMR_MSB:`TMR_LSB];
    else if (step_pulse && !timer_zero)
      balance_timeout_count_reg <= balance_timeout_count_reg - 4'h1;
  end

  // Seconds within one step
  always_ff @(posedge clk_in)
  begin
    if (reset_in || cfg_write || step_pulse)
      step_count_reg <= 5'h00;
    else if (sec_if.tick)
      step_count_reg <= step_count_reg + 5'h01;
  end

  // Read-all snapshot, taken on the strobe the serial logic gives
  // Capture timer for readback
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      timer_shown_reg <= `TMR_ZERO;
    else if (read_capture_in)
      timer_shown_reg <= balance_timeout_count_reg;
  end

  // Read data; other addresses answer zero
  wire [15:0] rdata_next;
  assign rdata_next = addr_hit ? {2'b00, balance_predivider_reg, timer_shown_reg,
                                  2'b00, aux_settle_count_reg} : 16'h0000;
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      rdata_reg <= 16'h0000;
    else
      rdata_reg <= rdata_next;
  end
  assign reg_rdata_out = rdata_reg;

  // Overtemperature comes from the analog side; accept only a settled level
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      ot_s1_reg    <= 1'b0;
      ot_s2_reg    <= 1'b0;
      ot_s3_reg    <= 1'b0;
      ot_level_reg <= 1'b0;
    end
    else
    begin
      ot_s1_reg <= die_overtemp_in;
      ot_s2_reg <= ot_s1_reg;
      ot_s3_reg <= ot_s2_reg;
      if (ot_s2_reg == ot_s3_reg)
        ot_level_reg <= ot_s3_reg;
    end
  end

  // Switch gating; either override alone turns every switch off
  wire        wd_expired;
  wire        force_off;
  assign wd_expired = timeout_on && timer_zero;
  assign force_off  = wd_expired || ot_level_reg;
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      switch_reg <= '0;
    else
      switch_reg <= force_off ? '0 : cell_balance_enable_in;
  end
  assign balance_switch_out = switch_reg;

  // Sequencer decode; a scan with no aux channel enabled is ignored
  wire        scan_accept;
  wire        first_chan;
  wire        more_chan;
  wire        settle_done;
  wire        enter_settle;
  assign scan_accept  = (state_reg == SEQ_IDLE) && scan_start_in && (|aux_enable_in);
  assign first_chan   = !aux_enable_in[0];
  assign more_chan    = !chan_reg && aux_enable_in[1];
  assign settle_done  = (state_reg == SEQ_SETTLE) && aux_if.tick &&
                        (settle_left_reg == `AUX_ZERO);
  assign enter_settle = scan_accept ||
                        ((state_reg == SEQ_CONVERT) && conv_done_in && more_chan);
  assign aux_if.restart = enter_settle;

  // Next state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      SEQ_IDLE:
        if (scan_accept)
          state_next = SEQ_SETTLE;
      SEQ_SETTLE:
        if (settle_done)
          state_next = SEQ_CONVERT;
      SEQ_CONVERT:
        if (conv_done_in)
          state_next = more_chan ? SEQ_SETTLE : SEQ_IDLE;
      default:
        state_next = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      state_reg <= SEQ_IDLE;
    else
      state_reg <= state_next;
  end

  // Channel and settle count; field is sampled per channel so a late write
  // applies from the next channel on
  // Full settle per channel
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      chan_reg         <= 1'b0;
      settle_left_reg  <= `AUX_ZERO;
      settle_field_reg <= `AUX_ZERO;
    end
    else if (enter_settle)
    begin
      chan_reg         <= scan_accept ? first_chan : 1'b1;
      settle_left_reg  <= aux_settle_count_reg;
      settle_field_reg <= aux_settle_count_reg;
    end
    else if ((state_reg == SEQ_SETTLE) && aux_if.tick)
      settle_left_reg <= settle_left_reg - 6'h01;
  end

  // Registered outputs of the sequencer
  // Bias only during sequence
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      convert_pulse_reg <= 1'b0;
      bias_reg          <= 1'b0;
    end
    else
    begin
      convert_pulse_reg <= settle_done;
      bias_reg          <= (state_next != SEQ_IDLE);
    end
  end
  assign aux_convert_start_out = convert_pulse_reg;
  assign aux_channel_out       = chan_reg;
  assign thermistor_bias_out   = bias_reg;
  assign scan_busy_out         = (state_reg != SEQ_IDLE);

  // Helper: cycles spent settling the current channel
  logic [15:0] settle_cyc_reg;
  always_ff @(posedge clk_in)
  begin
    if (reset_in || state_reg != SEQ_SETTLE)
      settle_cyc_reg <= 16'h0000;
    else
      settle_cyc_reg <= settle_cyc_reg + 16'h0001;
  end

  // Helper: cycles since the last step or restart of the step interval
  logic [31:0] step_cyc_reg;
  always_ff @(posedge clk_in)
  begin
    if (reset_in || cfg_write || step_pulse)
      step_cyc_reg <= 32'h00000000;
    else
      step_cyc_reg <= step_cyc_reg + 32'h00000001;
  end

  a_reserved_zero: assert property (@(posedge clk_in) disable iff (reset_in)
    rdata_reg[15:14] == 2'b00 && rdata_reg[7:6] == 2'b00)
    else $error("reserved bits read non-zero");
  a_no_limit: assert property (@(posedge clk_in) disable iff (reset_in)
    (balance_predivider_reg == `PDIV_OFF && !ot_level_reg)
      |=> balance_switch_out == $past(cell_balance_enable_in))
    else $error("switches limited with timeout disabled");
  a_step_ratio: assert property (@(posedge clk_in) disable iff (reset_in)
    step_pulse |-> 64'(step_cyc_reg) + 64'h1 == 64'(SEC_CYCLES) *
      ((balance_predivider_reg == `PDIV_1S) ? 64'h1 :
       (balance_predivider_reg == `PDIV_4S) ? 64'h4 : 64'h10))
    else $error("step not aligned to predivider");
  a_timer_step: assert property (@(posedge clk_in) disable iff (reset_in)
    (!cfg_write && !step_pulse) |=> $stable(balance_timeout_count_reg))
    else $error("timer moved without a step");
  a_expire_off: assert property (@(posedge clk_in) disable iff (reset_in)
    wd_expired |=> balance_switch_out == '0)
    else $error("switch on after watchdog expiry");
  a_capture_hold: assert property (@(posedge clk_in) disable iff (reset_in)
    read_capture_in |=> timer_shown_reg == $past(balance_timeout_count_reg))
    else $error("captured timer value wrong");
  a_settle_time: assert property (@(posedge clk_in) disable iff (reset_in)
    settle_done |-> 32'(settle_cyc_reg) + 32'h1 ==
      (32'(settle_field_reg) + 32'h1) * `AUX_STEP_CYCLES)
    else $error("settle time wrong");
  a_full_settle: assert property (@(posedge clk_in) disable iff (reset_in)
    enter_settle |=> settle_left_reg == $past(aux_settle_count_reg) ##1
      (state_reg == SEQ_SETTLE) [*8])
    else $error("settle cut short");
  a_aux_reset: assert property (@(posedge clk_in)
    reset_in |=> aux_settle_count_reg == `AUX_ZERO)
    else $error("aux field not reset to zero");
  a_bias_scan: assert property (@(posedge clk_in) disable iff (reset_in)
    scan_accept |=> thermistor_bias_out ##0 scan_busy_out)
    else $error("bias not on in sequence");
  a_bias_idle: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_reg == SEQ_IDLE && !scan_accept) [*2] |-> !thermistor_bias_out)
    else $error("bias on while idle");
  a_overtemp_off: assert property (@(posedge clk_in) disable iff (reset_in)
    ot_level_reg |=> balance_switch_out == '0)
    else $error("switch on during overtemperature");
  a_write_load: assert property (@(posedge clk_in) disable iff (reset_in)
    cfg_write |=> balance_timeout_count_reg == $past(reg_wdata_in[`TMR_MSB:`TMR_LSB])
      && step_count_reg == 5'h00)
    else $error("timer write not loaded");

  c_expiry:   cover property (@(posedge clk_in) disable iff (reset_in) $rose(wd_expired));
  c_convert0: cover property (@(posedge clk_in) disable iff (reset_in)
    aux_convert_start_out && !aux_channel_out);
  c_convert1: cover property (@(posedge clk_in) disable iff (reset_in)
    aux_convert_start_out && aux_channel_out);
  c_capture:  cover property (@(posedge clk_in) disable iff (reset_in)
    read_capture_in && !timer_zero);
endmodule // balance_watchdog
`default_nettype wire

// *** src/balance_watchdog_defs.svh ***
// Constants for the balancing watchdog and auxiliary settling block
`ifndef BALANCE_WATCHDOG_DEFS_SVH
`define BALANCE_WATCHDOG_DEFS_SVH
// Register address and layout
`define ACQ_CONFIG_ADDR   8'h0C
`define ACQ_CONFIG_RESET  16'h0000
`define PDIV_MSB          13
`define PDIV_LSB          12
`define TMR_MSB           11
`define TMR_LSB           8
`define AUX_MSB           5
`define AUX_LSB           0
// Predivider codes and step lengths in seconds, minus one
`define PDIV_OFF          2'h0
`define PDIV_1S           2'h1
`define PDIV_4S           2'h2
`define PDIV_16S          2'h3
`define STEP_1S_M1        5'h00
`define STEP_4S_M1        5'h03
`define STEP_16S_M1       5'h0F
`define TMR_ZERO          4'h0
`define AUX_ZERO          6'h00
// Clock and timing
`define CLK_HZ            50000000
`define CLK_MHZ           50
`define BAL_BASE_S        1
`define BAL_SEC_CYCLES    (`CLK_HZ * `BAL_BASE_S)
`define AUX_STEP_NS       5300
`define AUX_MAX_NS        339200
`define AUX_STEP_CYCLES   ((`AUX_STEP_NS * `CLK_MHZ + 999) / 1000)
`define CELL_COUNT        12
`endif

// *** src/balance_watchdog_pkg.sv ***
// Types shared by the balancing watchdog design
package balance_watchdog_pkg;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SETTLE, SEQ_CONVERT} seq_state_e;
  typedef logic [1:0] pdiv_t;
  typedef logic [3:0] timer_t;
  typedef logic [5:0] aux_t;
endpackage

// *** src/tick_if.sv ***
// Restart and tick signals between an interval timer and its user
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
  logic restart;
  logic tick;
  modport timer (input restart, output tick);
  modport user  (output restart, input tick);
endinterface
`default_nettype wire

// *** src/interval_tick.sv ***
// Free running interval timer giving a one-cycle tick every PERIOD cycles
`timescale 1ns/1ps
`default_nettype none
module interval_tick #(
  parameter int unsigned PERIOD = 265
) (
  input  wire logic clk_in,
  input  wire logic reset_in,
  tick_if.timer     port_if
);
  localparam int unsigned W = (PERIOD > 1) ? $clog2(PERIOD) : 1;
  localparam logic [W-1:0] LAST = W'(PERIOD - 1);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  wire          at_last;

  // Restart wins so the whole interval follows a restart
  assign at_last      = (count_reg == LAST);
  assign port_if.tick = at_last && !port_if.restart;
  assign count_next   = (port_if.restart || at_last) ? '0 : count_reg + W'(1);

  // Counter state
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end
endmodule // interval_tick
`default_nettype wire

// *** tb/aux_converter_model.sv ***
// Behavioural converter answering each auxiliary conversion request
`timescale 1ns/1ps
`default_nettype none
module aux_converter_model #(
  parameter int unsigned DELAY = 7
) (
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic convert_start_in,
  output logic      conv_done_out
);
  int unsigned busy_count;

  // One done pulse per request, DELAY cycles later; only one request is in flight
  always_ff @(posedge clk_in)
  begin
    conv_done_out <= 1'b0;
    if (reset_in)
      busy_count <= 0;
    else if (convert_start_in)
      busy_count <= DELAY;
    else if (busy_count != 0)
    begin
      busy_count <= busy_count - 1;
      conv_done_out <= (busy_count == 1);
    end
  end
endmodule // aux_converter_model
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the balancing watchdog and aux settling block
`timescale 1ns/1ps
`default_nettype none
`include "balance_watchdog_defs.svh"
module tb;
  import balance_watchdog_pkg::*;
  localparam int SEC = 20;
  logic        clk_in = 0, reset_in = 1, reg_wr_in = 0, read_capture_in = 0;
  logic [7:0]  reg_addr_in = `ACQ_CONFIG_ADDR;
  logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out;
  logic [11:0] cell_balance_enable_in = 12'h000, balance_switch_out;
  logic        die_overtemp_in = 0, scan_start_in = 0, conv_done_in;
  logic [1:0]  aux_enable_in = 2'h0;
  logic        aux_convert_start_out, aux_channel_out, thermistor_bias_out, scan_busy_out;
  int          failures = 0, checks_done = 0;

  balance_watchdog #(.SEC_CYCLES(SEC)) u_dut (.clk_in(clk_in), .reset_in(reset_in),
    .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .read_capture_in(read_capture_in), .reg_rdata_out(reg_rdata_out),
    .cell_balance_enable_in(cell_balance_enable_in), .die_overtemp_in(die_overtemp_in),
    .balance_switch_out(balance_switch_out), .scan_start_in(scan_start_in),
    .aux_enable_in(aux_enable_in), .conv_done_in(conv_done_in),
    .aux_convert_start_out(aux_convert_start_out), .aux_channel_out(aux_channel_out),
    .thermistor_bias_out(thermistor_bias_out), .scan_busy_out(scan_busy_out));
  aux_converter_model #(.DELAY(7)) u_conv (.clk_in(clk_in), .reset_in(reset_in),
    .convert_start_in(aux_convert_start_out), .conv_done_out(conv_done_in));

  // Clock of 20 ns period
  always #10 clk_in = ~clk_in;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  function automatic logic [15:0] word(logic [1:0] p, logic [3:0] t, logic [5:0] a);
    return {2'h0, p, t, 2'h0, a};
  endfunction

  // One write beat; inputs move 1 ns after the edge
  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    reg_wr_in = 1;
    reg_addr_in = a;
    reg_wdata_in = d;
    cycles(1);
    reg_wr_in = 0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
    reg_addr_in = a;
    cycles(1);
    d = reg_rdata_out;
    reg_addr_in = `ACQ_CONFIG_ADDR;
  endtask

  task automatic capture();
    read_capture_in = 1;
    cycles(1);
    read_capture_in = 0;
    cycles(1);
  endtask

  task automatic t_regs();
    logic [15:0] d;
    reg_read(`ACQ_CONFIG_ADDR, d);
    check("reset_word", d, 16'h0000);
    reg_write(`ACQ_CONFIG_ADDR, 16'hFFFF);
    reg_read(`ACQ_CONFIG_ADDR, d);
    check("reserved_zero", d, 16'h303F);
    capture();
    reg_read(`ACQ_CONFIG_ADDR, d);
    check("captured_word", d, 16'h3F3F);
    reg_read(8'h0B, d);
    check("unmapped_read", d, 16'h0000);
    $display("t_regs done");
  endtask

  task automatic t_no_timeout();
    cell_balance_enable_in = 12'h5A3;
    reg_write(`ACQ_CONFIG_ADDR, word(`PDIV_OFF, 4'h1, 6'h00));
    cycles(200);
    check("no_timeout_sw", balance_switch_out, 12'h5A3);
    cell_balance_enable_in = 12'h0F0;
    cycles(2);
    check("enable_follow", balance_switch_out, 12'h0F0);
    $display("t_no_timeout done");
  endtask

  task automatic t_steps();
    logic [1:0] p;
    int step;
    cell_balance_enable_in = 12'hFFF;
    for (int i = 1; i < 4; i++)
    begin
      p = i[1:0];
      step = (i == 1) ? 1 : (i == 2) ? 4 : 16;
      reg_write(`ACQ_CONFIG_ADDR, word(p, 4'h1, 6'h00));
      cycles(step * SEC - 4);
      check("step_still_on", balance_switch_out, 12'hFFF);
      cycles(8);
      check("step_expired", balance_switch_out, 12'h000);
    end
    $display("t_steps done");
  endtask

  // The read value is frozen at capture time, later counting is not seen
  task automatic t_capture();
    logic [15:0] d;
    reg_write(`ACQ_CONFIG_ADDR, word(`PDIV_1S, 4'h2, 6'h00));
    cycles(SEC + SEC / 2);
    capture();
    reg_read(`ACQ_CONFIG_ADDR, d);
    check("capture_one", d, word(`PDIV_1S, 4'h1, 6'h00));
    cycles(2 * SEC);
    reg_read(`ACQ_CONFIG_ADDR, d);
    check("capture_held", d, word(`PDIV_1S, 4'h1, 6'h00));
    $display("t_capture done");
  endtask

  task automatic t_rewrite();
    reg_write(`ACQ_CONFIG_ADDR, word(`PDIV_1S, 4'h1, 6'h00));
    cycles(15);
    // Host keep-alive before expiry
    reg_write(`ACQ_CONFIG_ADDR, word(`PDIV_1S, 4'h1, 6'h00));
    cycles(15);
    check("rewrite_on", balance_switch_out, 12'hFFF);
    cycles(10);
    check("rewrite_off", balance_switch_out, 12'h000);
    $display("t_rewrite done");
  endtask

  task automatic t_overtemp();
    cell_balance_enable_in = 12'hA5A;
    reg_write(`ACQ_CONFIG_ADDR, 16'h0000);
    cycles(3);
    die_overtemp_in = 1;
    cycles(8);
    check("overtemp_off", balance_switch_out, 12'h000);
    die_overtemp_in = 0;
    cycles(8);
    check("overtemp_back", balance_switch_out, 12'hA5A);
    $display("t_overtemp done");
  endtask

  task automatic count_to_start(output int n);
    n = 0;
    do
    begin
      cycles(1);
      n++;
    end while (aux_convert_start_out !== 1'b1 && n < 20000);
  endtask

  // Settling gap measured before every enabled channel
  task automatic t_scan(input logic [5:0] a, input logic [1:0] en);
    int n;
    int e;
    e = (a + 1) * 265;
    reg_write(`ACQ_CONFIG_ADDR, word(`PDIV_OFF, 4'h0, a));
    aux_enable_in = en;
    check("bias_idle", thermistor_bias_out, 1'b0);
    scan_start_in = 1;
    cycles(1);
    scan_start_in = 0;
    cycles(1);
    check("bias_run", thermistor_bias_out, 1'b1);
    count_to_start(n);
    check("first_gap", n, e - 1);
    check("first_chan", aux_channel_out, (en == 2'h2) ? 1'b1 : 1'b0);
    if (en == 2'h3)
    begin
      n = 0;
      while (conv_done_in !== 1'b1 && n < 100)
      begin
        cycles(1);
        n++;
      end
      count_to_start(n);
      check("second_gap", n, e + 1);
      check("second_chan", aux_channel_out, 1'b1);
    end
    n = 0;
    while (scan_busy_out !== 1'b0 && n < 100)
    begin
      cycles(1);
      n++;
    end
    check("bias_done", thermistor_bias_out, 1'b0);
    $display("t_scan done aux %0d", a);
  endtask

  // Watchdog cut-off well past the expected run length
  initial
  begin
    #2000000;
    failures++;
    complete_run();
  end

  initial
  begin
    cycles(4);
    reset_in = 0;
    t_regs();
    t_no_timeout();
    t_steps();
    t_capture();
    t_rewrite();
    t_overtemp();
    t_scan(6'h00, 2'h3);
    t_scan(6'h01, 2'h2);
    t_scan(6'h3F, 2'h1);
    complete_run();
  end
endmodule // tb
`default_nettype wire
